// [ioec_cell.sv]
// register logic of one programmable i/o element cell
`default_nettype none
`include "ioec_defs.svh"

// What this block does
// - each cell picks its own oe, clock enables, clears and clocks.
// - the input register may use its own clock and clock enable.
// - output and oe registers always share one clock and one enable.
// - all registers take clear or preset from one shared source.
// - registers start at a programmed high or low power-up value.
// - start-low registers are cleared, start-high ones are preset.
// - every register needing clear or preset uses the same signal.
// - a synchronous reset acting on the clock edge is also provided.
// - six registers allow data on both clock edges.
// - ddr input, ddr output and ddr bidirectional are selectable.
// - ddr input captures on rising and falling edges alternately.
// - a latch holds the high-phase bit so both bits meet one edge.
module ioec_cell
  import ioec_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire ioec_cfg_type cfg,
  input wire ioec_src_type src,
  input wire logic dataOutHi,
  input wire logic dataOutLo,
  output logic padOut,
  output logic padOe,
  output logic dataInHi,
  output logic dataInLo,
  output logic dataInValid
);

  ioec_state_type s_reg;
  ioec_state_type s_next;
  ioec_src_type srcS;

  logic inClk, outClk, inCe, outCe, aclr, sclr, oeVal, puVal;
  logic inRiseEv, inFallEv, outRiseEv, outFallEv, ddrIn, ddrOut;

  // pins and foreign clocks are levels sampled through two flops
  ioec_sync2 #(
    .WIDTH($bits(ioec_src_type))
  ) srcSync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(src),
    .syncOut(srcS)
  );

  function automatic logic pick(
    input logic [`IOEC_NSRC-1:0] bus,
    input logic [`IOEC_SEL_W-1:0] sel
  );
    pick = bus[sel];
  endfunction

  always_comb begin
    s_next = s_reg;
    inClk = pick(srcS.clk, cfg.inClkSel);
    outClk = pick(srcS.clk, cfg.outClkSel);
    inCe = pick(srcS.ce, cfg.inCeSel);
    outCe = pick(srcS.ce, cfg.outCeSel);
    aclr = pick(srcS.aclr, cfg.aclrSel);
    sclr = pick(srcS.sclr, cfg.sclrSel);
    oeVal = pick(srcS.oe, cfg.oeSel);
    puVal = cfg.powerUpHigh;
    inRiseEv = inClk & ~s_reg.inClkPrev;
    inFallEv = ~inClk & s_reg.inClkPrev;
    outRiseEv = outClk & ~s_reg.outClkPrev;
    outFallEv = ~outClk & s_reg.outClkPrev;
    case (cfg.mode)
      IOEC_DDR_IN: begin
        ddrIn = 1'b1;
        ddrOut = 1'b0;
      end
      IOEC_DDR_OUT: begin
        ddrIn = 1'b0;
        ddrOut = 1'b1;
      end
      IOEC_DDR_BIDIR: begin
        ddrIn = 1'b1;
        ddrOut = 1'b1;
      end
      default: begin
        ddrIn = 1'b0;
        ddrOut = 1'b0;
      end
    endcase
    s_next.inClkPrev = inClk;
    s_next.outClkPrev = outClk;
    s_next.dataInValid = 1'b0;

    // input side, own clock and enable
    if (inRiseEv && inCe) begin
      s_next.inRise = sclr ? puVal : srcS.pad;
      if (!ddrIn) begin
        s_next.dataInHi = s_next.inRise;
        s_next.dataInLo = s_next.inRise;
        s_next.dataInValid = 1'b1;
      end
    end
    if (inFallEv && inCe && ddrIn) begin
      s_next.inFall = sclr ? puVal : srcS.pad;
      // both bits handed over together on the falling edge
      s_next.dataInHi = s_reg.inLatch;
      s_next.dataInLo = s_next.inFall;
      s_next.dataInValid = 1'b1;
    end
    // transparent while the clock is high, closed while low
    if (inClk) begin
      s_next.inLatch = s_next.inRise;
    end

    // output and oe share one clock and one enable
    if (outRiseEv && outCe) begin
      s_next.outRise = sclr ? puVal : dataOutHi;
      s_next.oeRise = sclr ? puVal : oeVal;
    end
    if (outFallEv && outCe && ddrOut) begin
      s_next.outFall = sclr ? puVal : dataOutLo;
      s_next.oeFall = sclr ? puVal : oeVal;
    end

    // one shared clear/preset forces every capture, latch, output and oe register to its start value
    if (aclr) begin
      s_next.inRise = puVal;
      s_next.inFall = puVal;
      s_next.inLatch = puVal;
      s_next.outRise = puVal;
      s_next.outFall = puVal;
      s_next.oeRise = puVal;
      s_next.oeFall = puVal;
      // the captured pair is part of the cell's state, so it clears too
      s_next.dataInHi = puVal;
      s_next.dataInLo = puVal;
    end

    // pin mux; it lags the real clock level by the sync delay
    if (ddrOut) begin
      s_next.padOut = outClk ? s_next.outRise : s_next.outFall;
      // enable narrowed to both halves so a half bit is never driven
      s_next.padOe = s_next.oeRise & s_next.oeFall;
    end else begin
      s_next.padOut = s_next.outRise;
      s_next.padOe = s_next.oeRise & ~ddrIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // start value chosen per design: preset if high, clear if low
      s_reg.inRise <= cfg.powerUpHigh;
      s_reg.inFall <= cfg.powerUpHigh;
      s_reg.inLatch <= cfg.powerUpHigh;
      s_reg.outRise <= cfg.powerUpHigh;
      s_reg.outFall <= cfg.powerUpHigh;
      s_reg.oeRise <= cfg.powerUpHigh;
      s_reg.oeFall <= cfg.powerUpHigh;
      s_reg.dataInHi <= cfg.powerUpHigh;
      s_reg.dataInLo <= cfg.powerUpHigh;
      s_reg.dataInValid <= 1'b0;
      s_reg.padOut <= cfg.powerUpHigh;
      s_reg.padOe <= 1'b0;
      s_reg.inClkPrev <= 1'b0;
      s_reg.outClkPrev <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign padOut = s_reg.padOut;
  assign padOe = s_reg.padOe;
  assign dataInHi = s_reg.dataInHi;
  assign dataInLo = s_reg.dataInLo;
  assign dataInValid = s_reg.dataInValid;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence outCapture;
    outRiseEv && outCe && !sclr && !aclr;
  endsequence

  sequence ddrFallCapture;
    inFallEv && inCe && ddrIn && !sclr && !aclr;
  endsequence

  sequence sdrRiseCapture;
    inRiseEv && inCe && !ddrIn && !sclr && !aclr;
  endsequence

  shared_clear_a: assert property (
    aclr |=> (s_reg.inRise == $past(puVal)) && (s_reg.outFall == $past(puVal))
      && (s_reg.oeRise == $past(puVal)) && (s_reg.inLatch == $past(puVal)))
    else $error("clear/preset did not reach every register");

  clear_capture_a: assert property (
    aclr |=> (dataInHi == $past(puVal)) && (dataInLo == $past(puVal)))
    else $error("clear/preset did not reach the captured pair");

  sync_reset_a: assert property (
    outRiseEv && outCe && sclr && !aclr |=> s_reg.outRise == $past(puVal))
    else $error("synchronous reset missed on clock edge");

  out_launch_a: assert property (
    outCapture |=> (s_reg.outRise == $past(dataOutHi))
      && (s_reg.oeRise == $past(oeVal)))
    else $error("output and oe not taken on the same edge");

  out_hold_a: assert property (
    !(outRiseEv && outCe) && !aclr |=> $stable(s_reg.outRise))
    else $error("output register changed without an enabled edge");

  ddr_pair_a: assert property (
    ddrFallCapture |=> dataInValid && (dataInLo == $past(srcS.pad))
      && (dataInHi == $past(s_reg.inLatch)))
    else $error("ddr input pair not presented on falling edge");

  sdr_capture_a: assert property (
    sdrRiseCapture |=> dataInValid && (dataInHi == $past(srcS.pad)))
    else $error("single rate input not captured");

  latch_hold_a: assert property (
    !inClk && !aclr |=> $stable(s_reg.inLatch))
    else $error("input latch moved while clock low");

  ddr_pin_mux_a: assert property (
    ddrOut |=> padOut == (s_reg.outClkPrev ? s_reg.outRise : s_reg.outFall))
    else $error("ddr output mux picked the wrong register");

  oe_gate_a: assert property (
    padOe |-> s_reg.oeRise)
    else $error("pin driven while oe register deasserted");

  input_only_a: assert property (
    cfg.mode == IOEC_DDR_IN |=> !padOe)
    else $error("pin driven in ddr input mode");

endmodule
`default_nettype wire

// [ioec_defs.svh]
// constants shared by the i/o element cell files
`ifndef IOEC_DEFS_SVH
`define IOEC_DEFS_SVH

// number of candidate sources on each control bus
`define IOEC_NSRC 4
// width of a source selector
`define IOEC_SEL_W 2
// mode codes, one-hot
`define IOEC_MODE_SDR 4'h1
`define IOEC_MODE_DDR_IN 4'h2
`define IOEC_MODE_DDR_OUT 4'h4
`define IOEC_MODE_DDR_BIDIR 4'h8

`endif

// [ioec_pkg.sv]
// types of the i/o element cell
`default_nettype none
`include "ioec_defs.svh"
package ioec_pkg;

  typedef enum logic [3:0] {
    IOEC_SDR = `IOEC_MODE_SDR,
    IOEC_DDR_IN = `IOEC_MODE_DDR_IN,
    IOEC_DDR_OUT = `IOEC_MODE_DDR_OUT,
    IOEC_DDR_BIDIR = `IOEC_MODE_DDR_BIDIR
  } ioec_mode_type;

  // per-element selection of every control signal
  typedef struct packed {
    ioec_mode_type mode;
    logic powerUpHigh;
    logic [`IOEC_SEL_W-1:0] inClkSel;
    logic [`IOEC_SEL_W-1:0] outClkSel;
    logic [`IOEC_SEL_W-1:0] inCeSel;
    logic [`IOEC_SEL_W-1:0] outCeSel;
    logic [`IOEC_SEL_W-1:0] aclrSel;
    logic [`IOEC_SEL_W-1:0] sclrSel;
    logic [`IOEC_SEL_W-1:0] oeSel;
  } ioec_cfg_type;

  // candidate control sources arriving from outside the core clock
  typedef struct packed {
    logic [`IOEC_NSRC-1:0] clk;
    logic [`IOEC_NSRC-1:0] ce;
    logic [`IOEC_NSRC-1:0] aclr;
    logic [`IOEC_NSRC-1:0] sclr;
    logic [`IOEC_NSRC-1:0] oe;
    logic pad;
  } ioec_src_type;

  typedef struct packed {
    logic inRise;
    logic inFall;
    logic inLatch;
    logic outRise;
    logic outFall;
    logic oeRise;
    logic oeFall;
    logic dataInHi;
    logic dataInLo;
    logic dataInValid;
    logic padOut;
    logic padOe;
    logic inClkPrev;
    logic outClkPrev;
  } ioec_state_type;

endpackage
`default_nettype wire

// [ioec_sync2.sv]
// two-flop synchroniser for a bundle of levels
`default_nettype none
module ioec_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ioec_sync_type;

  ioec_sync_type s_reg;
  ioec_sync_type s_next;

  // stage1 feeds stage2 only, never any logic
  always_comb begin
    s_next.stage1 = asyncIn;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign syncOut = s_reg.stage2;

endmodule
`default_nettype wire

// [ioec_pin_dev.sv]
// pin-side device model that drives the pad whenever the cell lets go
`default_nettype none
module ioec_pin_dev (
  input wire logic padOut,
  input wire logic padOe,
  input wire logic drvVal,
  output logic pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // the far device backs off while the cell drives, so no contention
  always_comb begin
    if (padOe) begin
      pinLevel = padOut;
    end else begin
      pinLevel = drvVal;
    end
  end
endmodule
`default_nettype wire

// [io_element_ddr_registers_tb_top.sv]
// self-checking bench of the i/o element cell
`default_nettype none
module io_element_ddr_registers_tb_top import ioec_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  ioec_cfg_type cfg = '0;
  logic [3:0] clkV = 4'h0, ceV = 4'hf, aclrV = 4'h0, sclrV = 4'h0;
  logic [3:0] oeV = 4'h0;
  logic dataOutHi = 1'b0, dataOutLo = 1'b0, drvVal = 1'b0;
  logic padOut, padOe, dataInHi, dataInLo, dataInValid, pinLevel;
  ioec_src_type srcBus;
  int n_errors = 0, num_checks = 0;
  assign srcBus = {clkV, ceV, aclrV, sclrV, oeV, pinLevel};
  always #12.5 core_clk = ~core_clk;
  ioec_cell ioec_cell_i (.core_clk(core_clk), .reset_n(reset_n),
    .cfg(cfg), .src(srcBus), .dataOutHi(dataOutHi),
    .dataOutLo(dataOutLo), .padOut(padOut), .padOe(padOe),
    .dataInHi(dataInHi), .dataInLo(dataInLo),
    .dataInValid(dataInValid));
  ioec_pin_dev ioec_pin_dev_i (.padOut(padOut),
    .padOe(padOe), .drvVal(drvVal), .pinLevel(pinLevel));
  task results;
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // pad settles one edge ahead of the clock so both cross the syncs alike
  task elemClk(input int sel, input logic lvl, input logic pad);
    @(posedge core_clk);
    drvVal <= pad;
    @(posedge core_clk);
    clkV[sel] <= lvl;
  endtask
  task waitValid;
    for (int i = 0; i < 20 && dataInValid !== 1'b1; i++)
      @(negedge core_clk);
    if (dataInValid !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: no capture", $time);
      results();
    end
  endtask
  // every source on its own selector so a crossed mux shows up
  task start(input ioec_mode_type m, input logic puh, input logic oe);
    @(posedge core_clk);
    reset_n <= 1'b0;
    {clkV, aclrV, sclrV} <= 12'h000;
    ceV <= 4'hf;
    oeV <= {oe, 3'h0};
    dataOutHi <= 1'b0;
    cfg <= '{m, puh, 2'h1, 2'h2, 2'h0, 2'h3, 2'h1, 2'h2, 2'h3};
    cyc(6);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk(padOe, 1'b0);
    chk(padOut, puh);
    chk(dataInHi, puh);
    chk(dataInValid, 1'b0);
  endtask
  task s_sdr;
    start(IOEC_SDR, 1'b0, 1'b0);
    elemClk(1, 1'b1, 1'b1);
    waitValid();
    chk(dataInHi, 1'b1);
    chk(dataInLo, 1'b1);
    elemClk(1, 1'b0, 1'b0);
    ceV[0] <= 1'b0;
    cyc(4);
    elemClk(1, 1'b1, 1'b0);
    cyc(6);
    @(negedge core_clk);
    chk(dataInHi, 1'b1);
    elemClk(1, 1'b0, 1'b1);
    ceV[0] <= 1'b1;
    sclrV[2] <= 1'b1;
    cyc(4);
    elemClk(1, 1'b1, 1'b1);
    cyc(6);
    @(negedge core_clk);
    chk(dataInHi, 1'b0);
    // sync reset still high: an output edge must load the start value
    @(posedge core_clk);
    dataOutHi <= 1'b1;
    elemClk(2, 1'b1, 1'b0);
    cyc(5);
    @(negedge core_clk);
    chk(padOut, 1'b0);
  endtask
  task s_ddrin;
    logic a;
    start(IOEC_DDR_IN, 1'b0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      a = k[0];
      elemClk(1, 1'b1, a);
      cyc(4);
      elemClk(1, 1'b0, ~a);
      waitValid();
      chk(dataInHi, a);
      chk(dataInLo, ~a);
      chk(padOe, 1'b0);
    end
  endtask
  // pin enable needs both oe registers, so it only opens after a fall
  task s_ddrout(input ioec_mode_type m);
    start(m, 1'b0, 1'b1);
    @(posedge core_clk);
    dataOutHi <= 1'b1;
    dataOutLo <= 1'b0;
    elemClk(2, 1'b1, 1'b0);
    cyc(5);
    @(negedge core_clk);
    chk(padOut, 1'b1);
    elemClk(2, 1'b0, 1'b0);
    cyc(5);
    @(negedge core_clk);
    chk(padOut, 1'b0);
    chk(padOe, 1'b1);
    @(posedge core_clk);
    oeV[3] <= 1'b0;
    drvVal <= 1'b0;
    elemClk(2, 1'b1, 1'b0);
    cyc(5);
    @(negedge core_clk);
    chk(padOe, 1'b0);
    chk(pinLevel, 1'b0);
  endtask
  task s_aclr;
    start(IOEC_SDR, 1'b1, 1'b0);
    elemClk(2, 1'b1, 1'b0);
    // oe powers up high here; let the out edge release the pin first
    cyc(4);
    elemClk(1, 1'b1, 1'b0);
    waitValid();
    chk(dataInHi, 1'b0);
    chk(padOut, 1'b0);
    @(posedge core_clk);
    aclrV[1] <= 1'b1;
    cyc(5);
    @(negedge core_clk);
    chk(dataInHi, 1'b1);
    chk(dataInLo, 1'b1);
    chk(padOut, 1'b1);
  endtask
  initial begin
    s_sdr();
    s_ddrin();
    s_ddrout(IOEC_DDR_OUT);
    s_ddrout(IOEC_DDR_BIDIR);
    s_aclr();
    results();
  end
endmodule
`default_nettype wire
